// ==== rtl/xpc_params.svh ====
// constants of the crosspoint programming port: widths, slot counts, fields
// assumes inclusion by the package and by the design files that need it
`ifndef XPC_PARAMS_SVH
`define XPC_PARAMS_SVH

`define XPC_ADDR_W      3       // output select lines
`define XPC_SEL_W       4       // input select lines
`define XPC_WORD_W      5       // one slot: input select plus enable
`define XPC_SLOTS       8       // address slots, 8 x 5 = 40 bits
`define XPC_OUTS        5       // video outputs actually wired
`define XPC_EN_BIT      4       // enable bit position in a slot word
`define XPC_SYNC_W      12      // pins passed through the synchroniser
`define XPC_WORD_RST    5'h00   // slot contents after sys_rst

`endif

// ==== rtl/xpc_pkg.sv ====
// types shared by the crosspoint programming port files
// assumes xpc_params.svh is on the include path
`include "xpc_params.svh"

package xpc_pkg;
    typedef logic [`XPC_WORD_W-1:0] xpc_word_t;
    typedef logic [`XPC_SEL_W-1:0]  xpc_sel_t;
    typedef logic [`XPC_ADDR_W-1:0] xpc_addr_t;
endpackage

// ==== rtl/xpc_slot.sv ====
// one 5-bit slot: first-rank register and second-rank latch copy
// assumes load and xfer are already qualified by chip select, one clock
`timescale 1ns/1ps
`default_nettype none
`include "xpc_params.svh"

module xpc_slot (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic             xfer,
    input  wire xpc_pkg::xpc_word_t word_in,
    output var  xpc_pkg::xpc_word_t rank1_q,
    output var  xpc_pkg::xpc_word_t rank2_q
);

    ////////////////////////////////////////////////////////////////////////
    // first rank takes the presented word on a qualified falling edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rank1_q <= `XPC_WORD_RST;
        end else if (load) begin
            rank1_q <= word_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // second rank follows the first while transparent, else holds
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rank2_q <= `XPC_WORD_RST;
        end else if (xfer) begin
            rank2_q <= rank1_q;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/xpc_top.sv ====
// crosspoint parallel programming port: pin sync, slot load, latch transfer
// assumes all programming pins are asynchronous to clock; one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "xpc_params.svh"

module xpc_top (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  prog_clk,
    input  wire logic                  chip_sel_n,
    input  wire logic                  update_n,
    input  wire logic                  out_disable_n,
    input  wire logic                  out_sel_bit0,
    input  wire logic                  out_sel_bit1,
    input  wire logic                  out_sel_bit2,
    input  wire logic                  in_sel_bit0,
    input  wire logic                  in_sel_bit1,
    input  wire logic                  in_sel_bit2,
    input  wire logic                  in_sel_bit3,
    input  wire logic                  route_output_enable,
    output var  logic [`XPC_OUTS-1:0][`XPC_SEL_W-1:0] video_output_channel,
    output var  logic [`XPC_OUTS-1:0]  video_output_enable
);

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser for every pin; stage one feeds stage two only
    logic [`XPC_SYNC_W-1:0] pins_raw;
    logic [`XPC_SYNC_W-1:0] meta_r;
    logic [`XPC_SYNC_W-1:0] sync_r;
    logic                   clk_prev_r;

    assign pins_raw = {prog_clk, chip_sel_n, update_n, out_disable_n,
                       out_sel_bit2, out_sel_bit1, out_sel_bit0,
                       route_output_enable, in_sel_bit3, in_sel_bit2,
                       in_sel_bit1, in_sel_bit0};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            // all four control pins idle high, so release shows no edge
            meta_r <= {4'hf, 8'h00}; // strobes and clock idle high
            sync_r <= {4'hf, 8'h00};
        end else begin
            meta_r <= pins_raw;
            sync_r <= meta_r;
        end
    end

    // third stage only for edge detection, never the metastable stage
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            // must match the idle-high pin, else a false rise follows reset
            clk_prev_r <= 1'b1;
        end else begin
            clk_prev_r <= sync_r[11];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded views of the synchronised pins
    logic                 pclk_s;
    logic                 cs_n_s;
    logic                 upd_n_s;
    logic                 dis_n_s;
    xpc_pkg::xpc_addr_t   addr_s;
    xpc_pkg::xpc_word_t   word_s;
    logic                 pclk_fall;
    logic                 pclk_rise;
    logic                 load_go;
    logic                 xfer_go;

    assign pclk_s  = sync_r[11];
    assign cs_n_s  = sync_r[10];
    assign upd_n_s = sync_r[9];
    assign dis_n_s = sync_r[8];
    assign addr_s  = sync_r[7:5];           // bit 0 is the lsb
    assign word_s  = sync_r[4:0];           // [4] enable, [3:0] input

    // a pin pulse shorter than one clock cycle may be missed entirely
    // rising edges are seen but deliberately drive nothing
    assign pclk_fall = clk_prev_r & ~pclk_s;
    assign pclk_rise = ~clk_prev_r & pclk_s;

    // chip select gates both the load and the transfer path
    assign load_go = pclk_fall & ~cs_n_s & upd_n_s;
    assign xfer_go = ~cs_n_s & ~upd_n_s;

    ////////////////////////////////////////////////////////////////////////
    // eight slots form the 40-bit first rank and its latch rank
    xpc_pkg::xpc_word_t rank1 [`XPC_SLOTS];
    xpc_pkg::xpc_word_t rank2 [`XPC_SLOTS];

    genvar gi;
    generate
        for (gi = 0; gi < `XPC_SLOTS; gi++) begin : g_slot
            logic hit;
            assign hit = (addr_s == `XPC_ADDR_W'(gi));
            xpc_slot u_slot (
                .clock   (clock),
                .sys_rst (sys_rst),
                .load    (load_go & hit),
                .xfer    (xfer_go),
                .word_in (word_s),
                .rank1_q (rank1[gi]),
                .rank2_q (rank2[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // switch array drive; slots 5 to 7 are stored but reach no output
    // registered so a route word never glitches while a latch copies
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            video_output_channel <= '0;
        end else begin
            for (int k = 0; k < `XPC_OUTS; k++) begin
                video_output_channel[k] <= rank2[k][`XPC_SEL_W-1:0];
            end
        end
    end

    // disable only masks the enables, so latched routes survive it
    // limitation: disable passes the synchroniser, so it acts 3 cycles late
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            video_output_enable <= '0;
        end else begin
            for (int k = 0; k < `XPC_OUTS; k++) begin
                video_output_enable[k] <= rank2[k][`XPC_EN_BIT]
                                          & dis_n_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the design's own behaviour
    // all of them see the pins through the synchroniser, two cycles late
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    slot_load_a: assert property (
        load_go && addr_s == 3'h2 |=> rank1[2] == $past(word_s))
        else $error("addressed slot did not take the word");

    rise_ignore_a: assert property (
        pclk_rise |=> rank1[0] == $past(rank1[0])
                      && rank1[4] == $past(rank1[4]))
        else $error("rising edge changed the first rank");

    latch_follow_a: assert property (
        xfer_go ##1 xfer_go |=> rank2[3] == $past(rank1[3], 2))
        else $error("transparent latch did not follow first rank");

    latch_hold_a: assert property (
        upd_n_s |=> $stable(rank2[1]) && $stable(rank2[4]))
        else $error("latch changed while strobe high");

    cs_freeze_a: assert property (
        cs_n_s |=> $stable(rank1[0]) && $stable(rank2[0])
                   && $stable(rank1[7]) && $stable(rank2[7]))
        else $error("state changed with chip select high");

    cs_noload_a: assert property (
        cs_n_s && pclk_fall |=> rank1[addr_s] == $past(rank1[addr_s]))
        else $error("load taken with chip select high");

    disable_off_a: assert property (
        !dis_n_s |=> video_output_enable == '0)
        else $error("output enabled while disabled");

    disable_keep_a: assert property (
        !dis_n_s |=> video_output_channel[3] == $past(rank2[3][3:0])
                     && video_output_channel[1] == $past(rank2[1][3:0]))
        else $error("disable disturbed latched routes");

    enable_bit_a: assert property (
        dis_n_s ##1 dis_n_s |-> video_output_enable[0] == $past(rank2[0][4]))
        else $error("output enable not from stored bit");

    route_map_a: assert property (
        $stable(rank2[2]) |=> video_output_channel[2] == $past(rank2[2][3:0]))
        else $error("route select does not match latch");

    spare_slot_a: assert property (
        load_go && addr_s == 3'h7
        |=> $stable(rank1[4]) && rank1[7] == $past(word_s))
        else $error("spare slot load touched a live slot");

    load_addr_a: assert property (
        load_go && addr_s == 3'h4 |=> rank1[4] == $past(word_s)
                     && $stable(rank1[3]) && $stable(rank1[5]))
        else $error("load did not land in the addressed slot only");

    xfer_gate_a: assert property (
        !upd_n_s && cs_n_s |=> $stable(rank2[1]) && $stable(rank2[6]))
        else $error("transfer taken with chip select high");

    rst_clear_a: assert property (@(posedge clock) disable iff (1'b0)
        sys_rst |=> video_output_enable == '0 && rank2[0] == '0)
        else $error("reset left an output enabled");

    // main scenarios: load then transfer, disable, spare slot, refusal
    load_cov: cover property (load_go ##[1:40] xfer_go);
    disable_cov: cover property (video_output_enable[1] ##1 !dis_n_s);
    spare_cov: cover property (load_go && addr_s == 3'h6);
    refuse_cov: cover property (cs_n_s && pclk_fall);

endmodule
`default_nettype wire

// ==== tb/xpc_ctrl_model.sv ====
// controller model that drives the crosspoint programming pins
// assumes the bench clock; pins move 1 ns after its rising edge
`timescale 1ns/1ps
`default_nettype none

module xpc_ctrl_model (
    input  wire logic       clock,
    output var  logic       prog_clk,
    output var  logic       chip_sel_n,
    output var  logic       update_n,
    output var  logic       out_disable_n,
    output var  logic [2:0] addr,
    output var  logic [4:0] word
);
    ////////////////////////////////////////////////////////////////////
    // idle levels: deselected, strobes high
    initial begin
        prog_clk = 1'b1;
        chip_sel_n = 1'b1;
        update_n = 1'b1;
        out_disable_n = 1'b1;
        addr = 3'h0;
        word = 5'h00;
    end

    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one word into one slot; select held through the whole cycle
    task automatic load(input logic [2:0] a, input logic [4:0] w,
                        input logic cs_n);
        tick(1);
        addr = a;
        word = w;
        chip_sel_n = cs_n;
        tick(4);
        prog_clk = 1'b0;
        tick(4);
        // hold spent: lines turn over so a late or rising capture shows
        addr = ~a;
        word = ~w;
        tick(4);
        prog_clk = 1'b1;
        tick(4);
        chip_sel_n = 1'b1;
    endtask

    // strobe pulse, wide enough for the pin synchroniser
    task automatic xfer(input logic cs_n);
        tick(1);
        chip_sel_n = cs_n;
        tick(4);
        update_n = 1'b0;
        tick(4);
        update_n = 1'b1;
        tick(4);
        chip_sel_n = 1'b1;
    endtask

    // drive the disable pin and let it settle
    task automatic set_dis(input logic v);
        tick(1);
        out_disable_n = v;
        tick(5);
    endtask
endmodule
`default_nettype wire

// ==== tb/xpc_top_tb.sv ====
// self-checking bench for the crosspoint programming port
// assumes xpc_top and the controller model xpc_ctrl_model
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module xpc_top_tb;
    logic             clock;
    logic             sys_rst;
    wire logic        prog_clk, chip_sel_n, update_n, out_disable_n;
    wire logic [2:0]  addr;
    wire logic [4:0]  word;
    logic [4:0][3:0]  video_output_channel;
    logic [4:0]       video_output_enable;
    logic [3:0]       exp_ch [5], st_ch [5];
    logic             exp_en [5], st_en [5];
    int               err_total, n_checks;

    ////////////////////////////////////////////////////////////////////
    xpc_ctrl_model i_ctrl (.clock(clock), .prog_clk(prog_clk),
        .chip_sel_n(chip_sel_n), .update_n(update_n),
        .out_disable_n(out_disable_n), .addr(addr), .word(word));

    xpc_top i_dut (.clock(clock), .sys_rst(sys_rst), .prog_clk(prog_clk),
        .chip_sel_n(chip_sel_n), .update_n(update_n),
        .out_disable_n(out_disable_n), .out_sel_bit0(addr[0]),
        .out_sel_bit1(addr[1]), .out_sel_bit2(addr[2]),
        .in_sel_bit0(word[0]), .in_sel_bit1(word[1]),
        .in_sel_bit2(word[2]), .in_sel_bit3(word[3]),
        .route_output_enable(word[4]),
        .video_output_channel(video_output_channel),
        .video_output_enable(video_output_enable));

    ////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // compare all five outputs; dis masks the expected enables
    task automatic chk_all(input logic dis);
        for (int k = 0; k < 5; k++) begin
            `CHK("channel", exp_ch[k], video_output_channel[k])
            `CHK("enable", exp_en[k] & ~dis, video_output_enable[k])
        end
    endtask

    // slots 5 to 7 are stored but wired to nothing
    task automatic put(input logic [2:0] a, input logic [4:0] w,
                       input logic cs);
        i_ctrl.load(a, w, cs);
        if (!cs && a < 3'h5) begin
            st_ch[a] = w[3:0];
            st_en[a] = w[4];
        end
    endtask

    task automatic upd(input logic cs);
        i_ctrl.xfer(cs);
        if (!cs) begin
            exp_ch = st_ch;
            exp_en = st_en;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        sys_rst = 1'b1;
        err_total = 0;
        n_checks = 0;
        for (int k = 0; k < 5; k++) begin
            exp_ch[k] = 4'h0;
            exp_en[k] = 1'b0;
        end
        st_ch = exp_ch;
        st_en = exp_en;
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        i_ctrl.tick(4);
        chk_all(1'b0);
        for (int a = 0; a < 8; a++) put(3'(a), 5'h00, 1'b0);
        upd(1'b0);
        chk_all(1'b0);
        put(3'h2, 5'h15, 1'b0);
        chk_all(1'b0);
        upd(1'b0);
        chk_all(1'b0);
        for (int k = 0; k < 8; k++) put(3'(k), {k[0], 4'(15 - 3 * k)}, 1'b0);
        upd(1'b0);
        chk_all(1'b0);
        put(3'h1, 5'h0a, 1'b1);
        upd(1'b0);
        chk_all(1'b0);
        put(3'h1, 5'h1a, 1'b0);
        upd(1'b1);
        chk_all(1'b0);
        upd(1'b0);
        chk_all(1'b0);
        i_ctrl.set_dis(1'b0);
        chk_all(1'b1);
        i_ctrl.set_dis(1'b1);
        chk_all(1'b0);
        close_out();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
